/* File: design/dps_pkg.sv */
// ==========================================
// Register map and field layout
package dps_pkg;
  // Offsets are {A3, A2, 2'b00}
  localparam logic [3:0] DP_OFS_IDENT = 4'h0;
  localparam logic [3:0] DP_OFS_BANKED = 4'h4;
  localparam logic [3:0] DP_OFS_RESEND = 4'h8;
  localparam logic [3:0] DP_OFS_SELECT = 4'h8;
  localparam logic [3:0] DP_OFS_RDBUF = 4'hC;
  localparam logic [3:0] DP_OFS_TSEL = 4'hC;

  localparam logic [3:0] BANK_CTRL_STAT = 4'h0;
  localparam logic [3:0] BANK_LINK_CTRL = 4'h1;
  localparam logic [3:0] BANK_TARGET_ID = 4'h2;
  localparam logic [3:0] BANK_LINK_PROTO = 4'h3;
  localparam logic [3:0] BANK_EVENT = 4'h4;

  localparam int SEL_PORT_LSB = 24;
  localparam int SEL_BANK_LSB = 4;
  localparam int SEL_DBANK_LSB = 0;
  localparam logic [31:0] SELECT_RESET = 32'h0000_0000;
  localparam logic [31:0] READ_RESET = 32'h0000_0000;

  // ==========================================
  // Link framing, acknowledge codes sent LSB first
  localparam logic [2:0] ACK_OK = 3'h1;
  localparam logic [2:0] ACK_WAIT = 3'h2;
  localparam int REQ_BITS = 7;
  localparam int ACK_BITS = 3;
  localparam int DATA_BITS = 33;
  localparam int TS_GAP_BITS = 5;
  localparam int LINE_RESET_BITS = 50;
  localparam logic [5:0] REQ_LAST = 6'(REQ_BITS - 1);
  localparam logic [5:0] ACK_LAST = 6'(ACK_BITS - 1);
  localparam logic [5:0] DATA_LAST = 6'(DATA_BITS - 1);
  localparam logic [5:0] TS_GAP_LAST = 6'(TS_GAP_BITS - 1);
  localparam logic [5:0] LINE_RESET_LAST = 6'(LINE_RESET_BITS - 1);
  localparam logic [5:0] LINE_RESET_SAT = 6'(LINE_RESET_BITS);

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_REQ = 4'h1,
    S_TRN1 = 4'h2,
    S_ACK = 4'h3,
    S_RDATA = 4'h4,
    S_TRN2 = 4'h5,
    S_WDATA = 4'h6,
    S_TS_GAP = 4'h7,
    S_TS_DATA = 4'h8,
    S_LOCK = 4'h9
  } dps_link_state_t;

  function automatic logic dps_parity(input logic [31:0] v);
    dps_parity = ^v;
  endfunction

  function automatic logic [31:0] dps_target_ident(input logic [3:0] rev, input logic [15:0] part,
                                                    input logic [3:0] cont, input logic [6:0] ident);
    dps_target_ident = {rev, part, cont, ident, 1'b1};
  endfunction
endpackage

/* File: design/dps_xfer_if.sv */
`timescale 1ns/10ps
// ==========================================
// Access-port request crossing, toggle handshake
interface dps_xfer_if;
  logic req_tgl;
  logic req_write;
  logic [7:0] req_port;
  logic [3:0] req_bank;
  logic [1:0] req_a;
  logic [31:0] req_wdata;
  logic done_tgl;
  logic [31:0] rsp_rdata;
  modport link (output req_tgl, req_write, req_port, req_bank, req_a, req_wdata, input done_tgl, rsp_rdata);
  modport bridge (input req_tgl, req_write, req_port, req_bank, req_a, req_wdata, output done_tgl, rsp_rdata);
endinterface

/* File: design/dps_sync.sv */
`timescale 1ns/10ps
// ==========================================
// Two-flop synchroniser
module dps_sync (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_d,
  output logic o_q
);
  logic meta_r;
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta_r <= 1'b0;
      o_q <= 1'b0;
    end
    else
    begin
      meta_r <= i_d;
      o_q <= meta_r;
    end
  end
endmodule

/* File: design/dps_ap_bridge.sv */
`timescale 1ns/10ps
// ==========================================
// Core-side access-port master
module dps_ap_bridge
  import dps_pkg::*;
#(
  parameter int NUM_AP = 1
)(
  input wire logic i_clk,
  input wire logic i_rst_n,
  dps_xfer_if.bridge x_if,
  input wire logic i_ap_ready,
  input wire logic [31:0] i_ap_rdata,
  output logic o_ap_req,
  output logic o_ap_write,
  output logic [7:0] o_ap_port,
  output logic [7:0] o_ap_addr,
  output logic [31:0] o_ap_wdata
);
  initial
  begin
    if (NUM_AP < 1 || NUM_AP > 256)
      $error("NUM_AP must lie in 1..256");
  end

  localparam logic [8:0] AP_COUNT = 9'(NUM_AP);
  logic req_s;
  logic seen_r;
  wire new_req = (req_s != seen_r) && !o_ap_req;
  wire absent = {1'b0, x_if.req_port} >= AP_COUNT;
  wire finish = o_ap_req && i_ap_ready;

  dps_sync u_req_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_d(x_if.req_tgl),
    .o_q(req_s)
  );

  // Link holds request fields stable until done toggles back
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      seen_r <= 1'b0;
      o_ap_req <= 1'b0;
      o_ap_write <= 1'b0;
      o_ap_port <= 8'h00;
      o_ap_addr <= 8'h00;
      o_ap_wdata <= 32'h0000_0000;
      x_if.done_tgl <= 1'b0;
      x_if.rsp_rdata <= 32'h0000_0000;
    end
    else if (new_req)
    begin
      seen_r <= req_s;
      o_ap_port <= x_if.req_port;
      o_ap_write <= x_if.req_write;
      o_ap_wdata <= x_if.req_wdata;
      o_ap_addr <= {x_if.req_bank, x_if.req_a, 2'b00}; // RULE7
      if (absent)
      begin
        x_if.rsp_rdata <= 32'h0000_0000; // RULE6
        x_if.done_tgl <= ~x_if.done_tgl;
      end
      else
        o_ap_req <= 1'b1;
    end
    else if (finish)
    begin
      o_ap_req <= 1'b0;
      x_if.rsp_rdata <= o_ap_write ? 32'h0000_0000 : i_ap_rdata;
      x_if.done_tgl <= ~x_if.done_tgl;
    end
  end

  a_absent_silent: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    new_req && absent |=> !o_ap_req && x_if.rsp_rdata == 32'h0000_0000 && $changed(x_if.done_tgl)) // RULE6
    else $error("absent port was accessed or answered nonzero");
  a_bank_forward: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    new_req && !absent |=> o_ap_req && o_ap_addr[7:4] == $past(x_if.req_bank)) // RULE7
    else $error("port bank not forwarded");
  c_ap_done: cover property (@(posedge i_clk) disable iff (!i_rst_n) finish);
endmodule

/* File: design/dps_top.sv */
`timescale 1ns/10ps
// ==========================================
// What this block does
// RULE1 - Read at offset 0x8 returns the resend value for any debug bank.
// RULE2 - Resend read returns last port or read-buffer data, starting nothing new.
// RULE3 - Register address low two bits are zero; only word offsets decode.
// RULE4 - Write at offset 0x8 loads the selection register for any bank.
// RULE5 - Debugger never reads the selection register; it is write-only here.
// RULE6 - Port index bits 31:24 pick the port; absent port reads zero, ignores writes.
// RULE7 - Port bank bits 7:4 pick the four-word bank of the chosen port.
// RULE8 - Port index and bank are undefined after reset; debugger writes them first.
// RULE9 - Older ports need the debug bank written as zero by the debugger.
// RULE10 - Debug bank routes offset 0x4 to five registers, 0x0 through 0x4.
// RULE11 - Reserved debug bank values read as zero at offset 0x4.
// RULE12 - Reset clears the debug bank so offset 0x4 starts at control/status.
// RULE13 - Target identity: revision 31:28, part 27:12, designer 11:1, bit 0 one.
// RULE14 - Designer code: continuation count 11:8, identity low seven bits 7:1.
// RULE15 - Target identity reads at offset 0x4 with debug bank 0x2, version 2.
// RULE16 - Target-select after line reset selects on instance and identity match.
// RULE17 - Any other target-select value leaves the device deselected.
// RULE18 - All ones deselects every target; never a valid identity.
// RULE19 - Line stays undriven during the target-select acknowledge phase.
// RULE20 - Target-select is write-only at offset 0xC, any bank.
// RULE21 - Deselected device ignores packets, stays undriven until a line reset.
module dps_top
  import dps_pkg::*;
#(
  parameter int DP_VERSION = 2,
  parameter int NUM_AP = 1,
  parameter logic [3:0] INSTANCE_NUMBER = 4'h0,
  parameter logic [3:0] TARGET_REVISION = 4'h0,
  parameter logic [15:0] TARGET_PART_NUMBER = 16'h0001, // Arbitrary value
  parameter logic [3:0] DESIGNER_CONT_COUNT = 4'h0, // Arbitrary value
  parameter logic [6:0] DESIGNER_IDENT = 7'h15, // Arbitrary value
  parameter logic [31:0] PORT_IDENT_VALUE = 32'h0000_0001, // Arbitrary value
  parameter logic [27:0] LINK_PROTO_LOW = 28'h000_0001
)(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_swclk,
  input wire logic i_swdio_i,
  output logic o_swdio_o,
  output logic o_swdio_oe,
  output logic o_selected,
  output logic o_ap_req,
  output logic o_ap_write,
  output logic [7:0] o_ap_port,
  output logic [7:0] o_ap_addr,
  output logic [31:0] o_ap_wdata,
  input wire logic i_ap_ready,
  input wire logic [31:0] i_ap_rdata
);
  localparam logic [31:0] TARGET_IDENT = dps_target_ident(TARGET_REVISION, TARGET_PART_NUMBER,
                                                          DESIGNER_CONT_COUNT, DESIGNER_IDENT); // RULE13 RULE14
  localparam logic [31:0] LINK_PROTO = {INSTANCE_NUMBER, LINK_PROTO_LOW};
  localparam logic [31:0] MATCH_VALUE = {INSTANCE_NUMBER, TARGET_IDENT[27:0]};

  initial
  begin
    if (DP_VERSION != 1 && DP_VERSION != 2)
      $error("DP_VERSION must be 1 or 2");
    if (MATCH_VALUE == 32'hFFFF_FFFF)
      $error("target-select value of all ones is reserved for deselect"); // RULE18
  end

  // ==========================================
  // Resets and crossings
  logic rst_core_n;
  logic link_rst_n;
  logic done_s;
  dps_xfer_if x_if ();

  dps_sync u_core_rst (
    .i_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_d(1'b1),
    .o_q(rst_core_n)
  );
  // Link reset releases only once the probe clocks the line
  dps_sync u_link_rst (
    .i_clk(i_swclk),
    .i_rst_n(rst_core_n),
    .i_d(1'b1),
    .o_q(link_rst_n)
  );
  dps_sync u_done_sync (
    .i_clk(i_swclk),
    .i_rst_n(link_rst_n),
    .i_d(x_if.done_tgl),
    .o_q(done_s)
  );

  dps_ap_bridge #(
    .NUM_AP(NUM_AP)
  ) u_bridge (
    .i_clk(i_core_clk),
    .i_rst_n(rst_core_n),
    .x_if(x_if.bridge),
    .i_ap_ready(i_ap_ready),
    .i_ap_rdata(i_ap_rdata),
    .o_ap_req(o_ap_req),
    .o_ap_write(o_ap_write),
    .o_ap_port(o_ap_port),
    .o_ap_addr(o_ap_addr),
    .o_ap_wdata(o_ap_wdata)
  );

  // ==========================================
  // Link-side state
  dps_link_state_t state_r;
  logic [5:0] cnt_r;
  logic [5:0] ones_r;
  logic last_bit_r;
  logic armed_r;
  logic [6:0] req_sh_r;
  logic hdr_ap_r;
  logic hdr_rd_r;
  logic [3:0] hdr_ofs_r;
  logic [2:0] ack_r;
  logic [32:0] sh_r;
  logic [31:0] select_r;
  logic [31:0] resend_r;
  logic [31:0] rdbuf_r;
  logic done_seen_r;
  logic launch_rd_r;

  // ==========================================
  // Decode
  wire [6:0] req_full = {i_swdio_i, req_sh_r[6:1]};
  wire [32:0] w_full = {i_swdio_i, sh_r[32:1]};
  wire w_par_ok = dps_parity(w_full[31:0]) == w_full[32];
  wire hdr_ok = (dps_parity({28'h000_0000, req_full[3:0]}) == req_full[4]) && !req_full[5] && req_full[6];
  wire new_ap = req_full[0];
  wire new_rd = req_full[1];
  wire [3:0] new_ofs = {req_full[3], req_full[2], 2'b00}; // RULE3
  wire new_ts = armed_r && !new_ap && !new_rd && new_ofs == DP_OFS_TSEL; // RULE20
  wire ap_pending = x_if.req_tgl != done_s;
  wire new_wait = ap_pending && (new_ap || (new_rd && new_ofs == DP_OFS_RDBUF));
  wire [3:0] dbank = select_r[SEL_DBANK_LSB +: 4];
  wire bank_valid = (DP_VERSION == 2) ? (dbank <= BANK_EVENT) : (dbank <= BANK_LINK_CTRL); // RULE11
  // Control/status, link control and event status live outside this block and read zero
  wire [31:0] banked_val = !bank_valid ? 32'h0000_0000 :
                           (dbank == BANK_TARGET_ID) ? TARGET_IDENT : // RULE10 RULE15
                           (dbank == BANK_LINK_PROTO) ? LINK_PROTO : 32'h0000_0000;
  wire [31:0] rd_val = hdr_ap_r ? rdbuf_r :
                       (hdr_ofs_r == DP_OFS_IDENT) ? PORT_IDENT_VALUE :
                       (hdr_ofs_r == DP_OFS_BANKED) ? banked_val :
                       (hdr_ofs_r == DP_OFS_RESEND) ? resend_r : rdbuf_r; // RULE1
  wire ack_ok = ack_r == ACK_OK;
  wire rd_issue = state_r == S_TRN1 && ack_ok && hdr_rd_r;
  wire launch_rd = rd_issue && hdr_ap_r;
  wire buf_read = rd_issue && (hdr_ap_r || hdr_ofs_r == DP_OFS_RDBUF);
  wire w_commit = state_r == S_WDATA && cnt_r == DATA_LAST && w_par_ok;
  wire launch_wr = w_commit && hdr_ap_r;
  wire sel_commit = w_commit && !hdr_ap_r && hdr_ofs_r == DP_OFS_SELECT; // RULE4
  wire ts_done = state_r == S_TS_DATA && cnt_r == DATA_LAST;
  wire ts_match = w_full[31:0] == MATCH_VALUE && w_par_ok; // RULE16
  wire line_reset = i_swdio_i && ones_r == LINE_RESET_LAST;
  wire done_edge = done_s != done_seen_r;

  // ==========================================
  // Line reset detection
  always_ff @(posedge i_swclk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      ones_r <= 6'h00;
      last_bit_r <= 1'b1;
    end
    else
    begin
      last_bit_r <= i_swdio_i;
      if (!i_swdio_i)
        ones_r <= 6'h00;
      else if (ones_r != LINE_RESET_SAT)
        ones_r <= ones_r + 6'h01;
    end
  end

  // ==========================================
  // Packet engine
  always_ff @(posedge i_swclk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      state_r <= S_IDLE;
      cnt_r <= 6'h00;
      armed_r <= 1'b0;
      req_sh_r <= 7'h00;
      hdr_ap_r <= 1'b0;
      hdr_rd_r <= 1'b0;
      hdr_ofs_r <= 4'h0;
      ack_r <= ACK_OK;
      sh_r <= 33'h0_0000_0000;
      o_swdio_o <= 1'b0;
      o_swdio_oe <= 1'b0;
    end
    else if (line_reset)
    begin
      state_r <= S_IDLE; // RULE21
      armed_r <= 1'b1;
      o_swdio_oe <= 1'b0;
    end
    else
    begin
      case (state_r)
        S_IDLE:
          if (i_swdio_i && !last_bit_r)
          begin
            state_r <= S_REQ;
            cnt_r <= 6'h00;
          end
        S_REQ:
        begin
          req_sh_r <= req_full;
          cnt_r <= cnt_r + 6'h01;
          if (cnt_r == REQ_LAST)
          begin
            hdr_ap_r <= new_ap;
            hdr_rd_r <= new_rd;
            hdr_ofs_r <= new_ofs;
            ack_r <= new_wait ? ACK_WAIT : ACK_OK;
            cnt_r <= 6'h00;
            if (!hdr_ok)
              state_r <= S_IDLE;
            else if (new_ts)
            begin
              armed_r <= 1'b0;
              state_r <= S_TS_GAP; // RULE19
            end
            else if (!o_selected)
              state_r <= S_LOCK; // RULE21
            else
            begin
              armed_r <= 1'b0;
              state_r <= S_TRN1;
            end
          end
        end
        S_TRN1:
        begin
          state_r <= S_ACK;
          cnt_r <= 6'h00;
          o_swdio_oe <= 1'b1;
          o_swdio_o <= ack_r[0];
          sh_r <= {dps_parity(rd_val), rd_val};
        end
        S_ACK:
        begin
          cnt_r <= cnt_r + 6'h01;
          if (cnt_r != ACK_LAST)
            o_swdio_o <= ack_r[cnt_r[1:0] + 2'h1];
          else if (ack_ok && hdr_rd_r)
          begin
            state_r <= S_RDATA;
            cnt_r <= 6'h00;
            o_swdio_o <= sh_r[0];
            sh_r <= {1'b0, sh_r[32:1]};
          end
          else
          begin
            state_r <= S_TRN2;
            o_swdio_oe <= 1'b0;
          end
        end
        S_RDATA:
          if (cnt_r == DATA_LAST)
          begin
            state_r <= S_TRN2;
            o_swdio_oe <= 1'b0;
          end
          else
          begin
            cnt_r <= cnt_r + 6'h01;
            o_swdio_o <= sh_r[0];
            sh_r <= {1'b0, sh_r[32:1]};
          end
        S_TRN2:
        begin
          state_r <= (ack_ok && !hdr_rd_r) ? S_WDATA : S_IDLE;
          cnt_r <= 6'h00;
        end
        S_WDATA, S_TS_DATA:
        begin
          sh_r <= w_full;
          cnt_r <= cnt_r + 6'h01;
          if (cnt_r == DATA_LAST)
            state_r <= (state_r == S_WDATA || ts_match) ? S_IDLE : S_LOCK; // RULE17
        end
        S_TS_GAP:
        begin
          cnt_r <= cnt_r + 6'h01;
          if (cnt_r == TS_GAP_LAST)
          begin
            state_r <= S_TS_DATA;
            cnt_r <= 6'h00;
          end
        end
        S_LOCK:
          state_r <= S_LOCK;
        default:
          state_r <= S_IDLE;
      endcase
    end
  end

  // ==========================================
  // Registers behind the link
  // Port index and bank reset to zero as well, though software may not rely on it
  always_ff @(posedge i_swclk or negedge link_rst_n)
  begin
    if (!link_rst_n)
      select_r <= SELECT_RESET; // RULE12 RULE8
    else if (sel_commit)
      select_r <= w_full[31:0]; // RULE4 RULE5
  end

  always_ff @(posedge i_swclk or negedge link_rst_n)
  begin
    if (!link_rst_n)
      o_selected <= 1'b1;
    else if (ts_done)
      o_selected <= ts_match; // RULE16 RULE17
  end

  always_ff @(posedge i_swclk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      resend_r <= READ_RESET;
      rdbuf_r <= READ_RESET;
      done_seen_r <= 1'b0;
      launch_rd_r <= 1'b0;
    end
    else
    begin
      done_seen_r <= done_s;
      if (buf_read)
        resend_r <= rd_val; // RULE2
      if (done_edge && launch_rd_r)
        rdbuf_r <= x_if.rsp_rdata;
      if (launch_rd || launch_wr)
        launch_rd_r <= launch_rd;
    end
  end

  // Fields stay stable while a request is pending; WAIT keeps new ones out
  always_ff @(posedge i_swclk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      x_if.req_tgl <= 1'b0;
      x_if.req_write <= 1'b0;
      x_if.req_port <= 8'h00;
      x_if.req_bank <= 4'h0;
      x_if.req_a <= 2'h0;
      x_if.req_wdata <= 32'h0000_0000;
    end
    else if (launch_rd || launch_wr)
    begin
      x_if.req_tgl <= ~x_if.req_tgl;
      x_if.req_write <= launch_wr;
      x_if.req_port <= select_r[SEL_PORT_LSB +: 8]; // RULE6
      x_if.req_bank <= select_r[SEL_BANK_LSB +: 4]; // RULE7
      x_if.req_a <= hdr_ofs_r[3:2];
      x_if.req_wdata <= w_full[31:0];
    end
  end

  // ==========================================
  // Checks
  a_resend_quiet: assert property (@(posedge i_swclk) disable iff (!link_rst_n)
    rd_issue && !hdr_ap_r && hdr_ofs_r == DP_OFS_RESEND |=> $stable(x_if.req_tgl) && sh_r[31:0] == $past(resend_r)) // RULE2
    else $error("resend read started a port access or gave wrong data");
  a_select_load: assert property (@(posedge i_swclk) disable iff (!link_rst_n)
    sel_commit |=> select_r == $past(w_full[31:0])) // RULE4
    else $error("selection register not loaded");
  a_ts_undriven: assert property (@(posedge i_swclk) disable iff (!link_rst_n)
    state_r == S_TS_GAP || state_r == S_TS_DATA |-> !o_swdio_oe) // RULE19
    else $error("line driven during target select");
  a_lock_undriven: assert property (@(posedge i_swclk) disable iff (!link_rst_n)
    state_r == S_LOCK |-> !o_swdio_oe && $stable(x_if.req_tgl)) // RULE21
    else $error("deselected device reacted to the line");
  a_ident_route: assert property (@(posedge i_swclk) disable iff (!link_rst_n)
    rd_issue && !hdr_ap_r && hdr_ofs_r == DP_OFS_BANKED && dbank == BANK_TARGET_ID && DP_VERSION == 2
    |=> sh_r == {dps_parity(TARGET_IDENT), TARGET_IDENT}) // RULE15
    else $error("target identity not routed");
  a_reserved_zero: assert property (@(posedge i_swclk) disable iff (!link_rst_n)
    rd_issue && !hdr_ap_r && hdr_ofs_r == DP_OFS_BANKED && dbank > BANK_EVENT |=> sh_r == 33'h0_0000_0000) // RULE11
    else $error("reserved bank did not read zero");
  a_tsel_match: assert property (@(posedge i_swclk) disable iff (!link_rst_n)
    ts_done && ts_match |=> o_selected ##1 state_r != S_LOCK) // RULE16
    else $error("matching target select did not select");
  a_tsel_miss: assert property (@(posedge i_swclk) disable iff (!link_rst_n)
    ts_done && !ts_match |=> !o_selected && state_r == S_LOCK) // RULE17
    else $error("mismatching target select left device selected");
  a_ack_drive: assert property (@(posedge i_swclk) disable iff (!link_rst_n)
    state_r == S_TRN1 |=> o_swdio_oe [*3]) // Acknowledge driven for three bits after turnaround
    else $error("acknowledge not driven for three bits");

  c_ts_match: cover property (@(posedge i_swclk) disable iff (!link_rst_n) ts_done && ts_match);
  c_resend: cover property (@(posedge i_swclk) disable iff (!link_rst_n) rd_issue && hdr_ofs_r == DP_OFS_RESEND);
  c_wait: cover property (@(posedge i_swclk) disable iff (!link_rst_n) state_r == S_TRN1 && ack_r == ACK_WAIT);
endmodule

/* File: tb/dps_probe.sv */
`timescale 1ns/10ps
// ==========================================
// Probe: clock runs only inside frames, line pulled up when released
module dps_probe
  import dps_pkg::*;
(
  output logic o_swclk,
  output wire logic o_line,
  input wire logic i_dev_o,
  input wire logic i_dev_oe
);
  logic drv_en = 1'b1;
  logic drv_val = 1'b0;
  logic drove = 1'b0;
  initial o_swclk = 1'b0;
  assign o_line = i_dev_oe ? i_dev_o : (drv_en ? drv_val : 1'b1);
  // Sample just before the rising edge so device updates never race
  task automatic cyc(input logic b, output logic s);
    drv_val = b;
    #14 s = o_line;
    drove = drove | i_dev_oe;
    #1 o_swclk = 1'b1;
    #15 o_swclk = 1'b0;
  endtask
  task automatic lreset();
    logic s;
    drv_en = 1'b1;
    // Margin for the two link edges that release the link reset
    repeat (56) cyc(1'b1, s);
    repeat (2) cyc(1'b0, s);
  endtask
  task automatic xfer(input logic ap, input logic rnw, input logic [3:0] a, input logic [31:0] wd,
                      input logic ts, output logic [2:0] ack, output logic [31:0] rd);
    logic [7:0] hdr;
    logic [32:0] d;
    logic s;
    hdr = {1'b1, 1'b0, ^{ap, rnw, a[3:2]}, a[3], a[2], rnw, ap, 1'b1};
    drove = 1'b0;
    for (int i = 0; i < 8; i++) cyc(hdr[i], s);
    drv_en = 1'b0;
    cyc(1'b0, s);
    for (int i = 0; i < 3; i++) cyc(1'b0, ack[i]);
    if (rnw && ack == ACK_OK)
      for (int i = 0; i < 33; i++) cyc(1'b0, d[i]);
    rd = (d[32] === ^d[31:0]) ? d[31:0] : ~d[31:0];
    cyc(1'b0, s);
    drv_en = 1'b1;
    d = {^wd, wd};
    // Target select data follows the undriven response regardless of ack
    if (!rnw && (ack == ACK_OK || ts))
      for (int i = 0; i < 33; i++) cyc(d[i], s);
    repeat (2) cyc(1'b0, s);
  endtask
endmodule

/* File: tb/tb_dps_top.sv */
`timescale 1ns/10ps
module tb_dps_top;
  import dps_pkg::*;
  localparam logic [31:0] IDENT_EXP = 32'h3A5C_322B;
  localparam logic [31:0] PROTO_EXP = 32'h5000_0001;
  localparam logic [31:0] MATCH = 32'h5A5C_322B;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic swclk, line, dev_o, dev_oe, selected, ap_req, ap_write;
  logic [7:0] ap_port, ap_addr, last_port;
  logic [31:0] ap_wdata, rd, last_wd, n0;
  logic ap_ready = 1'b0;
  logic [31:0] ap_rdata = 32'h0000_0000;
  logic [8:0] last_addr;
  logic [2:0] ack;
  int n_req = 0;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  always #4 core_clk = ~core_clk;
  dps_top #(.NUM_AP(2), .INSTANCE_NUMBER(4'h5), .TARGET_REVISION(4'h3), .TARGET_PART_NUMBER(16'hA5C3),
    .DESIGNER_CONT_COUNT(4'h2), .DESIGNER_IDENT(7'h15)) dut ( // Identity values are arbitrary
    .i_core_clk(core_clk), .i_rst_n(rst_n), .i_swclk(swclk), .i_swdio_i(line), .o_swdio_o(dev_o),
    .o_swdio_oe(dev_oe), .o_selected(selected), .o_ap_req(ap_req), .o_ap_write(ap_write),
    .o_ap_port(ap_port), .o_ap_addr(ap_addr), .o_ap_wdata(ap_wdata), .i_ap_ready(ap_ready),
    .i_ap_rdata(ap_rdata));
  dps_probe p (.o_swclk(swclk), .o_line(line), .i_dev_o(dev_o), .i_dev_oe(dev_oe));
  // ==========================================
  // Port responder: one-cycle ready, data tagged by address
  always @(negedge core_clk)
  begin
    ap_ready <= ap_req & ~ap_ready;
    ap_rdata <= {24'hC0_DE00, ap_addr};
  end
  always @(posedge core_clk)
  begin
    cycles++;
    if (ap_req && ap_ready)
    begin
      n_req++;
      last_addr = {ap_write, ap_addr};
      last_wd = ap_wdata;
      last_port = ap_port;
    end
    if (cycles == 20000)
    begin
      num_errors++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic acc(input logic ap, input logic rnw, input logic [3:0] a, input logic [31:0] wd);
    ack = ACK_WAIT;
    for (int i = 0; i < 20 && ack == ACK_WAIT; i++) p.xfer(ap, rnw, a, wd, 1'b0, ack, rd);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ==========================================
  // Tests
  initial
  begin
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    p.lreset();
    acc(1'b0, 1'b1, 4'h4, 32'h0);
    chk("bank after reset", 32'h0, rd);
    for (int b = 0; b < 8; b++)
    begin
      acc(1'b0, 1'b0, 4'h8, 32'(b));
      acc(1'b0, 1'b1, 4'h4, 32'h0);
      chk("bank read", b == 2 ? IDENT_EXP : (b == 3 ? PROTO_EXP : 32'h0), rd);
    end
    acc(1'b0, 1'b0, 4'h8, 32'h0000_0035);
    acc(1'b1, 1'b1, 4'h4, 32'h0);
    chk("posted read", READ_RESET, rd);
    acc(1'b0, 1'b1, 4'hC, 32'h0);
    chk("read buffer", 32'hC0DE_0034, rd);
    chk("port addr", 32'h0000_0034, {23'h0, last_addr});
    n0 = n_req;
    acc(1'b0, 1'b1, 4'h8, 32'h0);
    chk("resend", 32'hC0DE_0034, rd);
    chk("resend no access", n0, n_req);
    acc(1'b0, 1'b0, 4'h8, 32'h0100_0030);
    acc(1'b1, 1'b0, 4'hC, 32'h1234_5678);
    acc(1'b0, 1'b1, 4'h0, 32'h0);
    chk("ident", 32'h0000_0001, rd);
    chk("port write", 32'h1234_5678, last_wd);
    chk("port write addr", 32'h0000_013C, {23'h0, last_addr});
    chk("port index", 32'h0000_0001, {24'h0, last_port});
    acc(1'b0, 1'b0, 4'h8, 32'h0200_0000);
    n0 = n_req;
    acc(1'b1, 1'b0, 4'h0, 32'hFFFF_FFFF);
    acc(1'b1, 1'b1, 4'h0, 32'h0);
    acc(1'b0, 1'b1, 4'hC, 32'h0);
    chk("absent read", 32'h0, rd);
    chk("absent no access", n0, n_req);
    p.lreset();
    p.xfer(1'b0, 1'b0, 4'hC, 32'hFFFF_FFFF, 1'b1, ack, rd);
    chk("select response drive", 32'h0, p.drove);
    chk("deselected", 32'h0, selected);
    p.xfer(1'b0, 1'b1, 4'h0, 32'h0, 1'b0, ack, rd);
    chk("locked drive", 32'h0, p.drove);
    p.lreset();
    p.xfer(1'b0, 1'b0, 4'hC, MATCH, 1'b1, ack, rd);
    chk("selected", 32'h1, selected);
    acc(1'b0, 1'b0, 4'hC, 32'h0);
    acc(1'b0, 1'b1, 4'h0, 32'h0);
    chk("late select ignored", 32'h1, {31'h0, selected});
    chk("ident after select", 32'h0000_0001, rd);
    summarize();
  end
endmodule
